// *** rtl/mdcfg_pkg.sv ***
// Constants, register map and types of the motor driver configuration bank
package mdcfg_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [7:0] OFS_PWMG = 8'h1D;
   localparam logic [7:0] OFS_PWM1 = 8'h20;
   localparam logic [7:0] OFS_DRV = 8'h22;
   localparam logic [7:0] OFS_CSA = 8'h23;
   localparam logic [7:0] OFS_SYS = 8'h3F;
   localparam int PAR_B = 15;
   localparam int PWMG_EN_B = 10;
   localparam int PWMG_CNT_LSB = 8;
   localparam int OSC_SRC_LSB = 5;
   localparam int CLK_SEL_LSB = 2;
   localparam int SYNC_ACC_LSB = 0;
   localparam int SSC_OFF_B = 2;
   localparam int PWM_MODE_LSB = 0;
   localparam int DLY_CMP_B = 7;
   localparam int DEAD_LSB = 4;
   localparam int SLEW_LSB = 0;
   localparam int CSA_ON_B = 3;
   localparam int SENSE_GAIN_LSB = 0;
   localparam int SYS_KEY_LSB = 12;
   localparam int SYS_LOCK_B = 7;
   localparam int SYS_PEN_B = 6;
   localparam logic [15:0] PWMG_WMASK = 16'h07FF;
   localparam logic [15:0] PWM1_WMASK = 16'h0007;
   localparam logic [15:0] DRV_WMASK = 16'h0FF3;
   localparam logic [15:0] CSA_WMASK = 16'h000B;
   localparam logic [15:0] SYS_WMASK = 16'h01FF;
   localparam logic [15:0] PWMG_RST = 16'h0000;
   localparam logic [15:0] PWM1_RST_BASE = 16'h0004;
   localparam logic [15:0] DRV_RST = 16'h0000;
   localparam logic [15:0] CSA_RST = 16'h0008;
   localparam logic [15:0] SYS_RST = 16'h0000;
   localparam logic [2:0] SYS_KEY = 3'h5;
   localparam logic [2:0] OSC_SRC_SCLK = 3'h7;
   localparam logic [1:0] PWM_MODE_THREE = 2'h2;
   localparam logic [1:0] PWM_MODE_GEN = 2'h3;
   localparam int CLK_MHZ = 125;
   localparam int DEAD_STEP_NS = 200;
   localparam int DEAD_STEP_CYC = (DEAD_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int SYNC_BASE_CYC = 512;
   localparam logic [9:0] SYNC_RST_CYC = 10'h200;

   typedef enum logic [2:0] {
      MDCFG_IN_SIX = 3'b001,
      MDCFG_IN_THREE = 3'b010,
      MDCFG_IN_GEN = 3'b100
   } mdcfg_in_mode_t;

   // Input scheme from the 2-bit mode code
   function automatic mdcfg_in_mode_t mdcfg_mode_f(input logic [1:0] code);
      return (code == PWM_MODE_GEN) ? MDCFG_IN_GEN :
             (code == PWM_MODE_THREE) ? MDCFG_IN_THREE : MDCFG_IN_SIX;
   endfunction

   // Dead time in core clock cycles, steps of 200 ns
   function automatic logic [7:0] mdcfg_dead_f(input logic [2:0] code);
      return 8'(int'(code) * DEAD_STEP_CYC);
   endfunction

   // Sync cycle count halves with each code step
   function automatic logic [9:0] mdcfg_sync_f(input logic [1:0] code);
      return 10'(SYNC_BASE_CYC >> code);
   endfunction
endpackage

// *** rtl/mdcfg_if.sv ***
// Interfaces between the bank core, its write gate and its setting decoder
`timescale 1ns/1ps
interface mdcfg_acc_if;
   import mdcfg_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic wr;
   logic lock;
   logic we_pwmg;
   logic we_pwm1;
   logic we_drv;
   logic we_csa;
   logic we_sys;
   logic hit;
   modport dec (input addr, wdata, wr, lock, output we_pwmg, we_pwm1, we_drv, we_csa, we_sys, hit);
   modport core (output addr, wdata, wr, lock, input we_pwmg, we_pwm1, we_drv, we_csa, we_sys, hit);
endinterface

interface mdcfg_set_if;
   import mdcfg_pkg::*;
   logic [DATA_W-1:0] pwmg;
   logic [DATA_W-1:0] pwm1;
   logic [DATA_W-1:0] drv;
   logic [9:0] sync_cycles;
   logic sclk_ref;
   mdcfg_in_mode_t mode;
   logic [7:0] dead_cycles;
   logic handshake_only;
   modport dec (input pwmg, pwm1, drv, output sync_cycles, sclk_ref, mode, dead_cycles, handshake_only);
   modport core (output pwmg, pwm1, drv, input sync_cycles, sclk_ref, mode, dead_cycles, handshake_only);
endinterface

// *** rtl/mdcfg_wr_gate.sv ***
// Address decode, write key check and lock gating
`timescale 1ns/1ps
module mdcfg_wr_gate
(
   mdcfg_acc_if.dec a
);
   import mdcfg_pkg::*;
   wire wr_open;
   wire key_ok;
   assign wr_open = a.wr && !a.lock;
   assign key_ok = (a.wdata[SYS_KEY_LSB +: 3] == SYS_KEY);
   assign a.we_pwmg = wr_open && (a.addr == OFS_PWMG);
   assign a.we_pwm1 = wr_open && (a.addr == OFS_PWM1);
   assign a.we_drv = wr_open && (a.addr == OFS_DRV);
   assign a.we_csa = wr_open && (a.addr == OFS_CSA);
   assign a.we_sys = a.wr && key_ok && (a.addr == OFS_SYS);
   assign a.hit = (a.addr == OFS_PWMG) || (a.addr == OFS_PWM1) || (a.addr == OFS_DRV) ||
                  (a.addr == OFS_CSA) || (a.addr == OFS_SYS);
endmodule

// *** rtl/mdcfg_set_dec.sv ***
// Decodes stored fields into settings for the driver logic
`timescale 1ns/1ps
module mdcfg_set_dec
(
   mdcfg_set_if.dec s
);
   import mdcfg_pkg::*;
   wire [2:0] dead_code;
   assign dead_code = s.drv[DEAD_LSB +: 3];
   assign s.sync_cycles = mdcfg_sync_f(s.pwmg[SYNC_ACC_LSB +: 2]);
   assign s.sclk_ref = (s.pwmg[OSC_SRC_LSB +: 3] == OSC_SRC_SCLK);
   assign s.mode = mdcfg_mode_f(s.pwm1[PWM_MODE_LSB +: 2]);
   assign s.dead_cycles = mdcfg_dead_f(dead_code);
   assign s.handshake_only = (dead_code == 3'h0);
endmodule

// *** rtl/mdcfg_regs.sv ***
// Configuration register bank of a three-phase motor driver
`timescale 1ns/1ps
module mdcfg_regs
#(
   parameter logic [1:0] P_PWM_MODE_RST = 2'h3
)
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [mdcfg_pkg::ADDR_W-1:0] i_addr,
   input wire logic [mdcfg_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [mdcfg_pkg::DATA_W-1:0] o_rdata,
   output logic [9:0] o_sync_cycles,
   output logic o_sclk_sync_ref,
   output logic [2:0] o_sync_clock_rate_select,
   output logic o_pwm_gen_enable,
   output logic [1:0] o_pwm_counter_mode,
   output logic o_spread_spectrum_on,
   output mdcfg_pkg::mdcfg_in_mode_t o_pwm_input_mode,
   output logic o_delay_compensation_on,
   output logic [7:0] o_dead_time_cycles,
   output logic o_handshake_only,
   output logic [1:0] o_edge_speed,
   output logic o_sense_amp_on,
   output logic [1:0] o_sense_amp_gain,
   output logic o_regs_locked,
   output logic o_parity_enable
);
   import mdcfg_pkg::*;

   localparam logic [15:0] PWM1_RST = PWM1_RST_BASE | {14'h0000, P_PWM_MODE_RST};
   localparam mdcfg_in_mode_t MODE_RST = mdcfg_mode_f(P_PWM_MODE_RST);

   // Even parity over the low fifteen bits
   function automatic logic par_f(input logic [15:0] w);
      return ^w[PAR_B-1:0];
   endfunction

   logic [15:0] pwmg_r;
   logic [15:0] pwm1_r;
   logic [15:0] drv_r;
   logic [15:0] csa_r;
   logic [15:0] sys_r;
   logic [15:0] rdata_r;
   logic [9:0] sync_cycles_r;
   logic sclk_ref_r;
   logic [2:0] clk_sel_r;
   logic pwm_gen_r;
   logic [1:0] cnt_mode_r;
   logic ssc_on_r;
   mdcfg_in_mode_t mode_r;
   logic dly_cmp_r;
   logic [7:0] dead_r;
   logic handshake_r;
   logic [1:0] edge_r;
   logic csa_on_r;
   logic [1:0] gain_r;
   logic lock_r;
   logic pen_r;

   wire [15:0] pwmg_nxt;
   wire [15:0] pwm1_nxt;
   wire [15:0] drv_nxt;
   wire [15:0] csa_nxt;
   wire [15:0] sys_nxt;
   wire [15:0] rd_word;
   wire [15:0] rd_raw;
   wire [15:0] rdata_nxt;
   wire rd_par;

   mdcfg_acc_if acc ();
   mdcfg_set_if set ();

   assign acc.addr = i_addr;
   assign acc.wdata = i_wdata;
   assign acc.wr = i_wr;
   assign acc.lock = sys_r[SYS_LOCK_B];

   mdcfg_wr_gate u_wr_gate
   (
      .a(acc)
   );

   assign set.pwmg = pwmg_r;
   assign set.pwm1 = pwm1_r;
   assign set.drv = drv_r;

   mdcfg_set_dec u_set_dec
   (
      .s(set)
   );

   assign pwmg_nxt = acc.we_pwmg ? (i_wdata & PWMG_WMASK) : pwmg_r;
   assign pwm1_nxt = acc.we_pwm1 ? (i_wdata & PWM1_WMASK) : pwm1_r;
   assign drv_nxt = acc.we_drv ? (i_wdata & DRV_WMASK) : drv_r;
   assign csa_nxt = acc.we_csa ? (i_wdata & CSA_WMASK) : csa_r;
   assign sys_nxt = acc.we_sys ? (i_wdata & SYS_WMASK) : sys_r;

   // Key field is write-only and never stored, so it reads zero
   assign rd_raw = (i_addr == OFS_PWMG) ? pwmg_r :
                   (i_addr == OFS_PWM1) ? pwm1_r :
                   (i_addr == OFS_DRV) ? drv_r :
                   (i_addr == OFS_CSA) ? csa_r : sys_r;
   assign rd_word = acc.hit ? rd_raw : 16'h0000;
   assign rd_par = sys_r[SYS_PEN_B] && par_f(rd_word);
   assign rdata_nxt = i_rd ? {rd_par, rd_word[PAR_B-1:0]} : 16'h0000;

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pwmg_r <= PWMG_RST;
         pwm1_r <= PWM1_RST;
         drv_r <= DRV_RST;
         csa_r <= CSA_RST;
         sys_r <= SYS_RST;
         rdata_r <= 16'h0000;
      end
      else
      begin
         pwmg_r <= pwmg_nxt;
         pwm1_r <= pwm1_nxt;
         drv_r <= drv_nxt;
         csa_r <= csa_nxt;
         sys_r <= sys_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Settings toward the driver, one cycle behind the stored fields
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sync_cycles_r <= SYNC_RST_CYC;
         sclk_ref_r <= 1'b0;
         clk_sel_r <= 3'h0;
         pwm_gen_r <= 1'b0;
         cnt_mode_r <= 2'h0;
         ssc_on_r <= 1'b0;
         mode_r <= MODE_RST;
         dly_cmp_r <= 1'b0;
         dead_r <= 8'h00;
         handshake_r <= 1'b1;
         edge_r <= 2'h0;
         csa_on_r <= 1'b1;
         gain_r <= 2'h0;
         lock_r <= 1'b0;
         pen_r <= 1'b0;
      end
      else
      begin
         sync_cycles_r <= set.sync_cycles;
         sclk_ref_r <= set.sclk_ref;
         clk_sel_r <= pwmg_r[CLK_SEL_LSB +: 3];
         pwm_gen_r <= pwmg_r[PWMG_EN_B];
         cnt_mode_r <= pwmg_r[PWMG_CNT_LSB +: 2];
         ssc_on_r <= !pwm1_r[SSC_OFF_B];
         mode_r <= set.mode;
         dly_cmp_r <= drv_r[DLY_CMP_B];
         dead_r <= set.dead_cycles;
         handshake_r <= set.handshake_only;
         edge_r <= drv_r[SLEW_LSB +: 2];
         csa_on_r <= csa_r[CSA_ON_B];
         gain_r <= csa_r[SENSE_GAIN_LSB +: 2];
         lock_r <= sys_r[SYS_LOCK_B];
         pen_r <= sys_r[SYS_PEN_B];
      end
   end

   assign o_rdata = rdata_r;
   assign o_sync_cycles = sync_cycles_r;
   assign o_sclk_sync_ref = sclk_ref_r;
   assign o_sync_clock_rate_select = clk_sel_r;
   assign o_pwm_gen_enable = pwm_gen_r;
   assign o_pwm_counter_mode = cnt_mode_r;
   assign o_spread_spectrum_on = ssc_on_r;
   assign o_pwm_input_mode = mode_r;
   assign o_delay_compensation_on = dly_cmp_r;
   assign o_dead_time_cycles = dead_r;
   assign o_handshake_only = handshake_r;
   assign o_edge_speed = edge_r;
   assign o_sense_amp_on = csa_on_r;
   assign o_sense_amp_gain = gain_r;
   assign o_regs_locked = lock_r;
   assign o_parity_enable = pen_r;

   // Checks
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence sys_key_wr_s;
      i_wr && (i_addr == OFS_SYS) && (i_wdata[SYS_KEY_LSB +: 3] == SYS_KEY);
   endsequence

   sequence drv_open_wr_s;
      i_wr && (i_addr == OFS_DRV) && !sys_r[SYS_LOCK_B];
   endsequence

   sequence drv_read_s;
      !i_wr && i_rd && (i_addr == OFS_DRV);
   endsequence

   read_parity_a: assert property (i_rd |=> o_rdata[PAR_B] == ($past(sys_r[SYS_PEN_B]) && par_f(o_rdata)))
      else $error("read parity bit wrong");

   read_idle_a: assert property (!i_rd |=> o_rdata == 16'h0000)
      else $error("read data outside read slot");

   key_reject_a: assert property (i_wr && (i_addr == OFS_SYS) && (i_wdata[SYS_KEY_LSB +: 3] != SYS_KEY)
                                  |=> $stable(sys_r))
      else $error("system write without key applied");

   key_apply_a: assert property (sys_key_wr_s ##1 !i_wr ##1 1'b1
                                 |-> o_regs_locked == $past(i_wdata[SYS_LOCK_B], 2))
      else $error("keyed system write not applied");

   sys_open_a: assert property (sys_key_wr_s |=> sys_r == ($past(i_wdata) & SYS_WMASK))
      else $error("keyed system write not stored");

   lock_hold_a: assert property (sys_r[SYS_LOCK_B] && i_wr && (i_addr != OFS_SYS)
                                 |=> $stable(pwmg_r) && $stable(pwm1_r) && $stable(drv_r) && $stable(csa_r))
      else $error("locked register changed");

   lock_follow_a: assert property (##1 o_regs_locked == $past(sys_r[SYS_LOCK_B]))
      else $error("lock output wrong");

   pwm1_apply_a: assert property (i_wr && (i_addr == OFS_PWM1) && !sys_r[SYS_LOCK_B]
                                  |=> pwm1_r == ($past(i_wdata) & PWM1_WMASK))
      else $error("open control one write not stored");

   drv_apply_a: assert property (drv_open_wr_s |=> drv_r == ($past(i_wdata) & DRV_WMASK))
      else $error("open driver control write not stored");

   csa_apply_a: assert property (i_wr && (i_addr == OFS_CSA) && !sys_r[SYS_LOCK_B]
                                 |=> csa_r == ($past(i_wdata) & CSA_WMASK))
      else $error("open sense control write not stored");

   drv_readback_a: assert property (drv_open_wr_s ##1 drv_read_s
                                    |=> o_rdata[11:0] == 12'($past(i_wdata, 2) & DRV_WMASK))
      else $error("driver control readback wrong");

   parity_off_a: assert property (i_rd && !sys_r[SYS_PEN_B] |=> !o_rdata[PAR_B])
      else $error("parity bit set while parity off");

   sync_count_a: assert property (##1 o_sync_cycles == mdcfg_sync_f($past(pwmg_r[SYNC_ACC_LSB +: 2])))
      else $error("sync cycle count wrong");

   sclk_ref_a: assert property (pwmg_r[OSC_SRC_LSB +: 3] == OSC_SRC_SCLK |=> o_sclk_sync_ref)
      else $error("serial clock sync reference not selected");

   sclk_off_a: assert property (pwmg_r[OSC_SRC_LSB +: 3] != OSC_SRC_SCLK |=> !o_sclk_sync_ref)
      else $error("serial clock sync reference selected wrongly");

   rate_follow_a: assert property (##1 o_sync_clock_rate_select == $past(pwmg_r[CLK_SEL_LSB +: 3]))
      else $error("sync clock rate select wrong");

   ssc_follow_a: assert property (##1 o_spread_spectrum_on == !$past(pwm1_r[SSC_OFF_B]))
      else $error("spread spectrum setting wrong");

   mode_map_a: assert property ((pwm1_r[PWM_MODE_LSB +: 2] == PWM_MODE_GEN)
                                |=> o_pwm_input_mode == MDCFG_IN_GEN)
      else $error("internal generation mode not selected");

   mode_three_a: assert property ((pwm1_r[PWM_MODE_LSB +: 2] == PWM_MODE_THREE)
                                  |=> o_pwm_input_mode == MDCFG_IN_THREE)
      else $error("three input mode not selected");

   mode_six_a: assert property ((pwm1_r[PWM_MODE_LSB +: 2] < PWM_MODE_THREE)
                                |=> o_pwm_input_mode == MDCFG_IN_SIX)
      else $error("six input mode not selected");

   dly_follow_a: assert property (##1 o_delay_compensation_on == $past(drv_r[DLY_CMP_B]))
      else $error("delay compensation output wrong");

   dead_time_a: assert property (##1 (o_dead_time_cycles == mdcfg_dead_f($past(drv_r[DEAD_LSB +: 3])))
                                 && (o_handshake_only == (o_dead_time_cycles == 8'h00)))
      else $error("dead time cycles wrong");

   edge_follow_a: assert property (##1 o_edge_speed == $past(drv_r[SLEW_LSB +: 2]))
      else $error("edge speed output wrong");

   sense_follow_a: assert property (##1 (o_sense_amp_on == $past(csa_r[CSA_ON_B]))
                                    && (o_sense_amp_gain == $past(csa_r[SENSE_GAIN_LSB +: 2])))
      else $error("sense amplifier setting wrong");

   parity_follow_a: assert property (##1 o_parity_enable == $past(sys_r[SYS_PEN_B]))
      else $error("parity enable output wrong");
endmodule

// *** verif/mdcfg_regs_tb_top.sv ***
// Self-checking testbench of the motor driver configuration bank
`timescale 1ns/1ps
module mdcfg_regs_tb_top;
   import mdcfg_pkg::*;
   typedef struct packed
   {
      logic [7:0] a;
      logic [15:0] d;
      logic [15:0] e;
   } mdcfg_row_t;
   logic i_core_clk;
   logic i_rst_n;
   logic [7:0] i_addr;
   logic [15:0] i_wdata;
   logic i_wr;
   logic i_rd;
   logic [15:0] o_rdata;
   logic [9:0] o_sync_cycles;
   logic o_sclk_sync_ref;
   logic [2:0] o_sync_clock_rate_select;
   logic o_pwm_gen_enable;
   logic [1:0] o_pwm_counter_mode;
   logic o_spread_spectrum_on;
   mdcfg_in_mode_t o_pwm_input_mode;
   logic o_delay_compensation_on;
   logic [7:0] o_dead_time_cycles;
   logic o_handshake_only;
   logic [1:0] o_edge_speed;
   logic o_sense_amp_on;
   logic [1:0] o_sense_amp_gain;
   logic o_regs_locked;
   logic o_parity_enable;
   int errors;
   int comparisons;
   logic [2:0] c;
   logic [2:0] m;
   mdcfg_row_t rows [8];
   mdcfg_row_t rst_rows [5];

   mdcfg_regs #(.P_PWM_MODE_RST(2'h3)) i_mdcfg_regs
   (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_sync_cycles(o_sync_cycles), .o_sclk_sync_ref(o_sclk_sync_ref),
      .o_sync_clock_rate_select(o_sync_clock_rate_select), .o_pwm_gen_enable(o_pwm_gen_enable),
      .o_pwm_counter_mode(o_pwm_counter_mode), .o_spread_spectrum_on(o_spread_spectrum_on),
      .o_pwm_input_mode(o_pwm_input_mode), .o_delay_compensation_on(o_delay_compensation_on),
      .o_dead_time_cycles(o_dead_time_cycles), .o_handshake_only(o_handshake_only),
      .o_edge_speed(o_edge_speed), .o_sense_amp_on(o_sense_amp_on), .o_sense_amp_gain(o_sense_amp_gain),
      .o_regs_locked(o_regs_locked), .o_parity_enable(o_parity_enable)
   );

   always #4 i_core_clk = ~i_core_clk;

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk_rd(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_out(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Bus write: one cycle strobe, called just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      i_wr <= 1'b1;
      i_rd <= 1'b0;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
   endtask

   // Bus read: data stand in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      i_rd <= 1'b1;
      i_wr <= 1'b0;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1;
      chk_rd("rdata", e, o_rdata);
   endtask

   // Setting outputs lag the register by one cycle
   task automatic settle();
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      #1;
   endtask

   task automatic chk_reset();
      for (int k = 0; k < 5; k++)
         rd(rst_rows[k].a, rst_rows[k].e);
      settle();
      chk_out("sync_cycles", 16'h0200, 16'(o_sync_cycles));
      chk_out("spread_on", 16'h0000, 16'(o_spread_spectrum_on));
      chk_out("input_mode", 16'h0004, 16'(o_pwm_input_mode));
      chk_out("delay_comp", 16'h0000, 16'(o_delay_compensation_on));
      chk_out("handshake", 16'h0001, 16'(o_handshake_only));
      chk_out("edge_speed", 16'h0000, 16'(o_edge_speed));
      chk_out("sense_on", 16'h0001, 16'(o_sense_amp_on));
      chk_out("sense_gain", 16'h0000, 16'(o_sense_amp_gain));
      chk_out("locked", 16'h0000, 16'(o_regs_locked));
      chk_out("parity_en", 16'h0000, 16'(o_parity_enable));
      $display("Test reset values done");
   endtask

   initial
   begin
      repeat (20000) @(posedge i_core_clk);
      errors++;
      $display("BAD watchdog expected finish seen hang");
      test_done();
   end

   initial
   begin
      i_core_clk = 1'b0;
      i_rst_n = 1'b0;
      i_addr = 8'h00;
      i_wdata = 16'h0000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      errors = 0;
      comparisons = 0;
      rows = '{'{8'h1D, 16'hFFFF, 16'h07FF}, '{8'h20, 16'hFFFF, 16'h0007}, '{8'h22, 16'hFFFF, 16'h0FF3},
               '{8'h23, 16'hFFFF, 16'h000B}, '{8'h3F, 16'h513F, 16'h013F}, '{8'h3F, 16'h6001, 16'h013F},
               '{8'h21, 16'hFFFF, 16'h0000}, '{8'h3F, 16'h5000, 16'h0000}};
      rst_rows = '{'{8'h1D, 16'h0, 16'h0000}, '{8'h20, 16'h0, 16'h0007}, '{8'h22, 16'h0, 16'h0000},
                   '{8'h23, 16'h0, 16'h0008}, '{8'h3F, 16'h0, 16'h0000}};
      repeat (3) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      @(posedge i_core_clk);
      chk_reset();
      // Write masks, write key and unmapped place, written then read back at once
      foreach (rows[k])
      begin
         wr(rows[k].a, rows[k].d);
         rd(rows[k].a, rows[k].e);
      end
      $display("Test masks and key done");
      // Every code of every field of the four lockable registers
      for (int i = 0; i < 8; i++)
      begin
         c = 3'(i);
         m = (c[1:0] == 2'h3) ? 3'b100 : (c[1:0] == 2'h2) ? 3'b010 : 3'b001;
         wr(8'h1D, 16'(c[0]) << 10 | 16'(c[1:0]) << 8 | 16'(c) << 5 | 16'(c) << 2 | 16'(c[1:0]));
         wr(8'h20, 16'(c[0]) << 2 | 16'(c[1:0]));
         wr(8'h22, 16'(c[0]) << 7 | 16'(c) << 4 | 16'(c[1:0]));
         wr(8'h23, 16'(c[0]) << 3 | 16'(c[1:0]));
         settle();
         chk_out("sync_cycles", 16'(10'h200 >> c[1:0]), 16'(o_sync_cycles));
         chk_out("sclk_ref", 16'(c == 3'h7), 16'(o_sclk_sync_ref));
         chk_out("rate_sel", 16'(c), 16'(o_sync_clock_rate_select));
         chk_out("gen_en", 16'(c[0]), 16'(o_pwm_gen_enable));
         chk_out("cnt_mode", 16'(c[1:0]), 16'(o_pwm_counter_mode));
         chk_out("spread_on", 16'(!c[0]), 16'(o_spread_spectrum_on));
         chk_out("input_mode", 16'(m), 16'(o_pwm_input_mode));
         chk_out("delay_comp", 16'(c[0]), 16'(o_delay_compensation_on));
         chk_out("dead_cycles", 16'(c) * 16'h0019, 16'(o_dead_time_cycles));
         chk_out("handshake", 16'(c == 3'h0), 16'(o_handshake_only));
         chk_out("edge_speed", 16'(c[1:0]), 16'(o_edge_speed));
         chk_out("sense_on", 16'(c[0]), 16'(o_sense_amp_on));
         chk_out("sense_gain", 16'(c[1:0]), 16'(o_sense_amp_gain));
      end
      $display("Test field codes done");
      // Parity bit on read, read data stand one cycle only
      wr(8'h3F, 16'h5040);
      settle();
      chk_out("parity_en", 16'h0001, 16'(o_parity_enable));
      wr(8'h22, 16'h0013);
      rd(8'h22, 16'h8013);
      rd(8'h3F, 16'h8040);
      @(posedge i_core_clk);
      #1;
      chk_rd("rdata_idle", 16'h0000, o_rdata);
      $display("Test parity done");
      // Lock blocks other registers, bad key ignored, good key unlocks
      wr(8'h3F, 16'h5080);
      settle();
      chk_out("locked", 16'h0001, 16'(o_regs_locked));
      wr(8'h22, 16'h0001);
      rd(8'h22, 16'h0013);
      wr(8'h23, 16'h0000);
      rd(8'h23, 16'h000B);
      wr(8'h3F, 16'h3000);
      rd(8'h3F, 16'h0080);
      wr(8'h3F, 16'h5000);
      rd(8'h3F, 16'h0000);
      wr(8'h22, 16'h0001);
      rd(8'h22, 16'h0001);
      $display("Test lock done");
      // Second reset in mid-run
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      @(posedge i_core_clk);
      chk_reset();
      test_done();
   end
endmodule
